// *** verilog/pfs_pin_select.v ***
// Pin function select for port1 bits 3 to 7 and port2 bit 0
`timescale 1ns/10ps
`default_nettype none
`include "pfs_defs.vh"

module pfs_pin_select (
  input wire mclk_i,
  input wire nrst_i,
  // Direction and general port output data
  input wire port1_bit3_direction_i,
  input wire port1_bit4_direction_i,
  input wire port1_bit5_direction_i,
  input wire port1_bit6_direction_i,
  input wire port1_bit7_direction_i,
  input wire port2_bit0_direction_i,
  input wire [7:3] port1_data_i,
  input wire port2_bit0_data_i,
  // Key input and analog selection
  input wire key_input3_enable_i,
  input wire adc_channel_bit2_i,
  input wire adc_channel_bit1_i,
  input wire adc_channel_bit0_i,
  input wire adc_group_select_i,
  // Serial unit controls and outputs
  input wire serial_mode_bit2_i,
  input wire serial_mode_bit1_i,
  input wire serial_mode_bit0_i,
  input wire serial_clock_source_select_i,
  input wire serial_open_drain_select_i,
  input wire serial0_transmit_i,
  input wire serial0_clock_out_i,
  // Timer A and interrupt controls
  input wire timer_a_pin_select_i,
  input wire timer_a_output_inhibit_i,
  input wire timer_a_mode_bit2_i,
  input wire timer_a_mode_bit1_i,
  input wire timer_a_mode_bit0_i,
  input wire timer_a_pulse_i,
  input wire ext_irq1_enable_i,
  // Timer D controls and waveforms
  input wire timer_d_a0_output_disable_i,
  input wire timer_d_combination_bit1_i,
  input wire timer_d_combination_bit0_i,
  input wire timer_d_ext_clock_select_i,
  input wire timer_d_three_phase_select_i,
  input wire timer_d_a0_io_bit2_i,
  input wire timer_d_a0_io_bit1_i,
  input wire timer_d_a0_io_bit0_i,
  input wire timer_d_three_phase_wave_i,
  input wire timer_d_compare_wave_i,
  // Pull-up and drive controls
  input wire pullup_group2_i,
  input wire pullup_group3_i,
  input wire pullup_group4_i,
  input wire port2_bit0_high_drive_i,
  // Pad levels
  input wire [7:3] pad_p1_in_i,
  input wire pad_p2_0_in_i,
  // Pad drive
  output reg [7:3] pad_p1_out_o,
  output reg [7:3] pad_p1_oe_o,
  output reg [7:3] pad_p1_pullup_o,
  output reg pad_p2_0_out_o,
  output reg pad_p2_0_oe_o,
  output reg pad_p2_0_pullup_o,
  output reg pad_p2_0_high_drive_o,
  // Peripheral inputs
  output reg key_input3_o,
  output reg analog_channel11_sel_o,
  output reg serial0_receive_o,
  output reg serial0_clock_in_o,
  output reg timer_a_io_in_o,
  output reg ext_irq1_o,
  output reg timer_d_a0_capture_o,
  output reg timer_d_ext_clock_o,
  // Port read-back
  output reg [7:3] port1_read_o,
  output reg port2_bit0_read_o
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  // Pull-up only while the pin is an input and its group is enabled
  function pullup_on(input oe, input group_en);
    pullup_on = group_en & ~oe;
  endfunction

  // Gate an input to a peripheral, idle level when not selected
  function gate_in(input sel, input level, input idle);
    gate_in = sel ? level : idle;
  endfunction

  // --------------------------------------------------------------------------
  // Decoded control fields
  // --------------------------------------------------------------------------
  wire [2:0] serial_mode;
  wire [2:0] timer_a_mode;
  wire [2:0] adc_channel;
  wire [1:0] timer_d_combination;
  wire [2:0] timer_d_a0_io;
  assign serial_mode = {serial_mode_bit2_i, serial_mode_bit1_i, serial_mode_bit0_i};
  assign timer_a_mode = {timer_a_mode_bit2_i, timer_a_mode_bit1_i, timer_a_mode_bit0_i};
  assign adc_channel = {adc_channel_bit2_i, adc_channel_bit1_i, adc_channel_bit0_i};
  assign timer_d_combination = {timer_d_combination_bit1_i, timer_d_combination_bit0_i};
  assign timer_d_a0_io = {timer_d_a0_io_bit2_i, timer_d_a0_io_bit1_i, timer_d_a0_io_bit0_i};

  // Transmit modes and clock-sync mode
  wire tx_mode;
  wire clksync_mode;
  assign tx_mode = (serial_mode == `PFS_SMD_CLKSYNC) | (serial_mode == `PFS_SMD_UART7) |
                   (serial_mode == `PFS_SMD_UART8) | (serial_mode == `PFS_SMD_UART9);
  assign clksync_mode = (serial_mode == `PFS_SMD_CLKSYNC);

  // Timer A pulse output active on the selected pin
  wire ta_pulse_mode;
  wire ta_on_bit5;
  wire ta_on_bit7;
  assign ta_pulse_mode = (timer_a_mode == `PFS_TMOD_PULSE) & ~timer_a_output_inhibit_i;
  assign ta_on_bit5 = (timer_a_pin_select_i == `PFS_TA_PIN_BIT5);
  assign ta_on_bit7 = (timer_a_pin_select_i == `PFS_TA_PIN_BIT7);

  // Timer D plain timer mode with internal clock
  wire td_timer_base;
  assign td_timer_base = (timer_d_combination == `PFS_TD_CMD_TIMER) & ~timer_d_ext_clock_select_i;

  // --------------------------------------------------------------------------
  // Port1 bit3: general port, key input, analog channel
  // --------------------------------------------------------------------------
  reg nxt_p1_3_out;
  reg nxt_p1_3_oe;
  reg nxt_p1_3_pu;
  reg nxt_key3;
  reg nxt_ch11;
  always @* begin
    nxt_p1_3_oe = port1_bit3_direction_i;
    nxt_p1_3_out = port1_data_i[3];
    nxt_p1_3_pu = pullup_on(port1_bit3_direction_i, pullup_group2_i);
    nxt_key3 = gate_in(~port1_bit3_direction_i & key_input3_enable_i, pad_p1_in_i[3],
                       `PFS_IDLE_HIGH);
    nxt_ch11 = ~port1_bit3_direction_i & (adc_channel == `PFS_AD_CH11) &
               (adc_group_select_i == `PFS_AD_GRP_HIGH);
  end

  // --------------------------------------------------------------------------
  // Port1 bit4: general port or serial transmit
  // --------------------------------------------------------------------------
  reg nxt_p1_4_out;
  reg nxt_p1_4_oe;
  always @* begin
    if (tx_mode) begin
      // Transmit owns the pad whatever the direction bit says
      if (serial_open_drain_select_i) begin
        nxt_p1_4_out = `PFS_IDLE_LOW;
        nxt_p1_4_oe = ~serial0_transmit_i;
      end else begin
        nxt_p1_4_out = serial0_transmit_i;
        nxt_p1_4_oe = `PFS_IDLE_HIGH;
      end
    end else begin
      nxt_p1_4_out = port1_data_i[4];
      nxt_p1_4_oe = port1_bit4_direction_i;
    end
  end

  // --------------------------------------------------------------------------
  // Port1 bit5: receive, timer A, interrupt 1
  // --------------------------------------------------------------------------
  reg nxt_p1_5_out;
  reg nxt_p1_5_oe;
  reg nxt_rx;
  reg ta_in5;
  always @* begin
    if (ta_on_bit5 & ta_pulse_mode) begin
      nxt_p1_5_out = timer_a_pulse_i;
      nxt_p1_5_oe = `PFS_IDLE_HIGH;
    end else begin
      nxt_p1_5_out = port1_data_i[5];
      nxt_p1_5_oe = port1_bit5_direction_i;
    end
    // Receive sees the pin while it is an input and timer A does not drive it
    nxt_rx = gate_in(~port1_bit5_direction_i & ~(ta_on_bit5 & ta_pulse_mode),
                     pad_p1_in_i[5], `PFS_IDLE_HIGH);
    ta_in5 = ~port1_bit5_direction_i & ta_on_bit5 & (timer_a_mode != `PFS_TMOD_PULSE);
  end

  // --------------------------------------------------------------------------
  // Port1 bit6: general port or serial clock
  // --------------------------------------------------------------------------
  reg nxt_p1_6_out;
  reg nxt_p1_6_oe;
  reg nxt_clk_in;
  always @* begin
    if (clksync_mode & ~serial_clock_source_select_i) begin
      nxt_p1_6_out = serial0_clock_out_i;
      nxt_p1_6_oe = `PFS_IDLE_HIGH;
    end else begin
      nxt_p1_6_out = port1_data_i[6];
      nxt_p1_6_oe = port1_bit6_direction_i;
    end
    nxt_clk_in = gate_in(~port1_bit6_direction_i & serial_clock_source_select_i,
                         pad_p1_in_i[6], `PFS_IDLE_HIGH);
  end

  // --------------------------------------------------------------------------
  // Port1 bit7: timer A, interrupt 1
  // --------------------------------------------------------------------------
  reg nxt_p1_7_out;
  reg nxt_p1_7_oe;
  reg ta_in7;
  always @* begin
    if (ta_on_bit7 & ta_pulse_mode) begin
      nxt_p1_7_out = timer_a_pulse_i;
      nxt_p1_7_oe = `PFS_IDLE_HIGH;
    end else begin
      nxt_p1_7_out = port1_data_i[7];
      nxt_p1_7_oe = port1_bit7_direction_i;
    end
    ta_in7 = ~port1_bit7_direction_i & ta_on_bit7 & (timer_a_mode != `PFS_TMOD_PULSE);
  end

  // Timer A input and interrupt 1 come from whichever pin is selected
  wire nxt_ta_in;
  wire nxt_irq1;
  wire ta_level;
  assign ta_level = ta_on_bit5 ? pad_p1_in_i[5] : pad_p1_in_i[7];
  assign nxt_ta_in = gate_in(ta_in5 | ta_in7, ta_level, `PFS_IDLE_LOW);
  assign nxt_irq1 = gate_in((ta_in5 | ta_in7) & ext_irq1_enable_i, ta_level, `PFS_IDLE_LOW);

  // --------------------------------------------------------------------------
  // Port2 bit0: timer D pin or general port
  // --------------------------------------------------------------------------
  reg nxt_p2_0_out;
  reg nxt_p2_0_oe;
  reg nxt_cap;
  reg nxt_extclk;
  reg td_three_phase;
  reg td_compare;
  always @* begin
    td_three_phase = ~timer_d_a0_output_disable_i & td_timer_base &
                     ~timer_d_three_phase_select_i;
    td_compare = ~timer_d_a0_output_disable_i & td_timer_base & timer_d_three_phase_select_i &
                 ((timer_d_a0_io == `PFS_TD_IO_CMP) |
                  (timer_d_a0_io[2:1] == `PFS_TD_IO_CMP_HI));
    if (td_three_phase) begin
      nxt_p2_0_out = timer_d_three_phase_wave_i;
      nxt_p2_0_oe = `PFS_IDLE_HIGH;
    end else if (td_compare) begin
      nxt_p2_0_out = timer_d_compare_wave_i;
      nxt_p2_0_oe = `PFS_IDLE_HIGH;
    end else begin
      nxt_p2_0_out = port2_bit0_data_i;
      nxt_p2_0_oe = port2_bit0_direction_i;
    end
    nxt_cap = gate_in(~port2_bit0_direction_i & td_timer_base & timer_d_three_phase_select_i &
                      timer_d_a0_io[`PFS_TD_IO_CAP_BIT], pad_p2_0_in_i, `PFS_IDLE_LOW);
    nxt_extclk = gate_in(~port2_bit0_direction_i & timer_d_ext_clock_select_i &
                         timer_d_three_phase_select_i & (timer_d_a0_io == `PFS_TD_IO_EXTCLK),
                         pad_p2_0_in_i, `PFS_IDLE_LOW);
  end

  // --------------------------------------------------------------------------
  // Collected pad drive
  // --------------------------------------------------------------------------
  wire [7:3] nxt_p1_out;
  wire [7:3] nxt_p1_oe;
  wire [7:3] nxt_p1_pu;
  assign nxt_p1_out = {nxt_p1_7_out, nxt_p1_6_out, nxt_p1_5_out, nxt_p1_4_out, nxt_p1_3_out};
  assign nxt_p1_oe = {nxt_p1_7_oe, nxt_p1_6_oe, nxt_p1_5_oe, nxt_p1_4_oe, nxt_p1_3_oe};
  assign nxt_p1_pu = {pullup_on(nxt_p1_7_oe, pullup_group3_i),
                      pullup_on(nxt_p1_6_oe, pullup_group3_i),
                      pullup_on(nxt_p1_5_oe, pullup_group3_i),
                      pullup_on(nxt_p1_4_oe, pullup_group3_i),
                      nxt_p1_3_pu};

  // --------------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------------
  // All outputs registered; reset leaves every pin an undriven input
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pad_p1_out_o <= `PFS_RST_P1;
      pad_p1_oe_o <= `PFS_RST_P1;
      pad_p1_pullup_o <= `PFS_RST_P1;
      pad_p2_0_out_o <= `PFS_RST_BIT;
      pad_p2_0_oe_o <= `PFS_RST_BIT;
      pad_p2_0_pullup_o <= `PFS_RST_BIT;
      pad_p2_0_high_drive_o <= `PFS_RST_BIT;
      key_input3_o <= `PFS_IDLE_HIGH;
      analog_channel11_sel_o <= `PFS_RST_BIT;
      serial0_receive_o <= `PFS_IDLE_HIGH;
      serial0_clock_in_o <= `PFS_IDLE_HIGH;
      timer_a_io_in_o <= `PFS_IDLE_LOW;
      ext_irq1_o <= `PFS_IDLE_LOW;
      timer_d_a0_capture_o <= `PFS_IDLE_LOW;
      timer_d_ext_clock_o <= `PFS_IDLE_LOW;
      port1_read_o <= `PFS_RST_P1;
      port2_bit0_read_o <= `PFS_RST_BIT;
    end else begin
      pad_p1_out_o <= nxt_p1_out;
      pad_p1_oe_o <= nxt_p1_oe;
      pad_p1_pullup_o <= nxt_p1_pu;
      pad_p2_0_out_o <= nxt_p2_0_out;
      pad_p2_0_oe_o <= nxt_p2_0_oe;
      pad_p2_0_pullup_o <= pullup_on(nxt_p2_0_oe, pullup_group4_i);
      pad_p2_0_high_drive_o <= port2_bit0_high_drive_i & nxt_p2_0_oe;
      key_input3_o <= nxt_key3;
      analog_channel11_sel_o <= nxt_ch11;
      serial0_receive_o <= nxt_rx;
      serial0_clock_in_o <= nxt_clk_in;
      timer_a_io_in_o <= nxt_ta_in;
      ext_irq1_o <= nxt_irq1;
      timer_d_a0_capture_o <= nxt_cap;
      timer_d_ext_clock_o <= nxt_extclk;
      port1_read_o <= pad_p1_in_i;
      port2_bit0_read_o <= pad_p2_0_in_i;
    end
  end
endmodule
`default_nettype wire

// *** common/pfs_defs.vh ***
// Constants for the port pin function select block
`ifndef PFS_DEFS_VH
`define PFS_DEFS_VH

// ----------------------------------------------------------------------------
// Serial mode encodings
// ----------------------------------------------------------------------------
`define PFS_SMD_OFF 3'h0
`define PFS_SMD_CLKSYNC 3'h1
`define PFS_SMD_UART7 3'h4
`define PFS_SMD_UART8 3'h5
`define PFS_SMD_UART9 3'h6

// ----------------------------------------------------------------------------
// Timer A, analog and timer D encodings
// ----------------------------------------------------------------------------
`define PFS_TMOD_PULSE 3'h1
`define PFS_TA_PIN_BIT7 1'h0
`define PFS_TA_PIN_BIT5 1'h1
`define PFS_AD_CH11 3'h7
`define PFS_AD_GRP_HIGH 1'h1
`define PFS_TD_CMD_TIMER 2'h0
`define PFS_TD_IO_EXTCLK 3'h0
`define PFS_TD_IO_CMP 3'h1
`define PFS_TD_IO_CMP_HI 2'h1
`define PFS_TD_IO_CAP_BIT 2

// ----------------------------------------------------------------------------
// Reset values and levels fed to idle peripheral inputs
// ----------------------------------------------------------------------------
`define PFS_RST_BIT 1'h0
`define PFS_RST_P1 5'h00
`define PFS_IDLE_HIGH 1'h1
`define PFS_IDLE_LOW 1'h0

`endif

// *** test/pfs_periph_model.sv ***
// Peripheral side model feeding waveforms into the pin select block
`timescale 1ns/10ps
`default_nettype none
module pfs_periph_model (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  output logic tx_o,
  output logic sclk_o,
  output logic pulse_o,
  output logic wave3_o,
  output logic cmp_o
);
  logic [1:0] cnt_ff;
  // Pattern advances only while peripherals run
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= 2'h0;
    end else if (run_i) begin
      cnt_ff <= cnt_ff + 2'h1;
    end
  end
  // Serial clock idles high outside activity
  assign sclk_o = !run_i || cnt_ff[0];
  assign tx_o = cnt_ff[0];
  assign pulse_o = !cnt_ff[0];
  assign wave3_o = cnt_ff[0] ^ cnt_ff[1];
  assign cmp_o = !cnt_ff[0];
endmodule
`default_nettype wire

// *** test/pfs_pin_select_props.sv ***
// Assertions on the pin select block ports
`timescale 1ns/10ps
`default_nettype none
module pfs_pin_select_props (
  input wire logic mclk_i, nrst_i, port1_bit3_direction_i, port1_bit5_direction_i, port2_bit0_direction_i,
  input wire logic [7:3] port1_data_i, pad_p1_in_i, pad_p1_out_o, pad_p1_oe_o, pad_p1_pullup_o,
  input wire logic key_input3_enable_i, adc_channel_bit2_i, adc_channel_bit1_i, adc_channel_bit0_i,
  input wire logic adc_group_select_i, serial_mode_bit2_i, serial_mode_bit1_i, serial_mode_bit0_i,
  input wire logic serial_clock_source_select_i, serial_open_drain_select_i, serial0_transmit_i,
  input wire logic serial0_clock_out_i, timer_a_pin_select_i, timer_a_output_inhibit_i, timer_a_pulse_i,
  input wire logic timer_a_mode_bit2_i, timer_a_mode_bit1_i, timer_a_mode_bit0_i, ext_irq1_enable_i,
  input wire logic timer_d_a0_output_disable_i, timer_d_combination_bit1_i, timer_d_combination_bit0_i,
  input wire logic timer_d_ext_clock_select_i, timer_d_three_phase_select_i, timer_d_a0_io_bit2_i,
  input wire logic timer_d_a0_io_bit1_i, timer_d_a0_io_bit0_i, timer_d_three_phase_wave_i,
  input wire logic timer_d_compare_wave_i, pullup_group2_i, pullup_group3_i, pullup_group4_i,
  input wire logic port2_bit0_high_drive_i, pad_p2_0_in_i, pad_p2_0_out_o, pad_p2_0_oe_o,
  input wire logic pad_p2_0_pullup_o, pad_p2_0_high_drive_o, key_input3_o, analog_channel11_sel_o,
  input wire logic serial0_receive_o, ext_irq1_o, timer_a_io_in_o, timer_d_a0_capture_o
);
  // Decoded control fields
  wire logic [2:0] smd = {serial_mode_bit2_i, serial_mode_bit1_i, serial_mode_bit0_i};
  wire logic [2:0] tmod = {timer_a_mode_bit2_i, timer_a_mode_bit1_i, timer_a_mode_bit0_i};
  wire logic [2:0] ioa = {timer_d_a0_io_bit2_i, timer_d_a0_io_bit1_i, timer_d_a0_io_bit0_i};
  wire logic ch11_sel = {adc_channel_bit2_i, adc_channel_bit1_i, adc_channel_bit0_i} == 3'h7 && adc_group_select_i;
  wire logic tx_mode = smd == 3'h1 || smd[2] && smd != 3'h7;
  wire logic ta_pulse = tmod == 3'h1 && !timer_a_output_inhibit_i;
  wire logic td_base = !timer_d_combination_bit1_i && !timer_d_combination_bit0_i && !timer_d_ext_clock_select_i;
  wire logic td_out = !timer_d_a0_output_disable_i && td_base &&
    (!timer_d_three_phase_select_i || ioa == 3'h1 || ioa[2:1] == 2'h1);
  wire logic td_wave = timer_d_three_phase_select_i ? timer_d_compare_wave_i : timer_d_three_phase_wave_i;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  tx_drive_a: assert property (tx_mode && !serial_open_drain_select_i |=>
    pad_p1_oe_o[4] && pad_p1_out_o[4] == $past(serial0_transmit_i)) else $error("transmit not driven");
  tx_odrain_a: assert property (tx_mode && serial_open_drain_select_i |=>
    pad_p1_oe_o[4] == !$past(serial0_transmit_i) && !(pad_p1_oe_o[4] && pad_p1_out_o[4]))
    else $error("open drain transmit drives high");
  clk_out_a: assert property (smd == 3'h1 && !serial_clock_source_select_i |=>
    pad_p1_oe_o[6] && pad_p1_out_o[6] == $past(serial0_clock_out_i)) else $error("serial clock not driven");
  pulse_pin_a: assert property (ta_pulse |=>
    ($past(timer_a_pin_select_i) ? pad_p1_oe_o[5] && pad_p1_out_o[5] == $past(timer_a_pulse_i)
    : pad_p1_oe_o[7] && pad_p1_out_o[7] == $past(timer_a_pulse_i))) else $error("pulse on wrong pin");
  irq_route_a: assert property (timer_a_pin_select_i && tmod != 3'h1 && !port1_bit5_direction_i &&
    ext_irq1_enable_i |=> ext_irq1_o == $past(pad_p1_in_i[5]) && timer_a_io_in_o == $past(pad_p1_in_i[5])
    && serial0_receive_o == $past(pad_p1_in_i[5])) else $error("bit5 input routing wrong");
  key_adc_a: assert property (!port1_bit3_direction_i |=>
    key_input3_o == ($past(key_input3_enable_i) ? $past(pad_p1_in_i[3]) : 1'h1)
    && analog_channel11_sel_o == $past(ch11_sel)) else $error("bit3 input routing wrong");
  pull_group_a: assert property ($past(nrst_i) |-> pad_p1_pullup_o ==
    ({{4{$past(pullup_group3_i)}}, $past(pullup_group2_i)} & ~pad_p1_oe_o)) else $error("pull-up wrong");
  td_capture_a: assert property (!port2_bit0_direction_i && td_base && timer_d_three_phase_select_i
    && ioa[2] |=> timer_d_a0_capture_o == $past(pad_p2_0_in_i)) else $error("capture input wrong");
  td_wave_a: assert property (td_out |=>
    pad_p2_0_oe_o && pad_p2_0_out_o == $past(td_wave)) else $error("timer D waveform not driven");
  p20_port_a: assert property (timer_d_a0_output_disable_i |=>
    pad_p2_0_oe_o == $past(port2_bit0_direction_i) && pad_p2_0_pullup_o == ($past(pullup_group4_i)
    && !$past(port2_bit0_direction_i))) else $error("port2 bit0 general port wrong");
  high_drive_a: assert property ($past(nrst_i) |->
    pad_p2_0_high_drive_o == ($past(port2_bit0_high_drive_i) && pad_p2_0_oe_o)) else $error("drive wrong");

  cover property (tx_mode && serial_open_drain_select_i);
  cover property (ta_pulse && timer_a_pin_select_i);
  cover property (td_out && timer_d_three_phase_select_i);
endmodule
bind pfs_pin_select pfs_pin_select_props u_props (.*);
`default_nettype wire

// *** test/test_port_pin_function_select.sv ***
// Testbench for the port pin function select block
`timescale 1ns/10ps
`default_nettype none
module test_port_pin_function_select;
  logic mclk_i = '0, nrst_i = '0, run = '0, port1_bit3_direction_i = '0, port1_bit4_direction_i = '0;
  logic port1_bit5_direction_i = '0, port1_bit6_direction_i = '0, port1_bit7_direction_i = '0;
  logic port2_bit0_direction_i = '0, port2_bit0_data_i = '0, key_input3_enable_i = '0, adc_channel_bit2_i = '0;
  logic adc_channel_bit1_i = '0, adc_channel_bit0_i = '0, adc_group_select_i = '0, serial_mode_bit2_i = '0;
  logic serial_mode_bit1_i = '0, serial_mode_bit0_i = '0, serial_clock_source_select_i = '0;
  logic serial_open_drain_select_i = '0, timer_a_pin_select_i = '0, timer_a_output_inhibit_i = '0;
  logic timer_a_mode_bit2_i = '0, timer_a_mode_bit1_i = '0, timer_a_mode_bit0_i = '0, ext_irq1_enable_i = '0;
  logic timer_d_a0_output_disable_i = '0, timer_d_combination_bit1_i = '0, timer_d_combination_bit0_i = '0;
  logic timer_d_ext_clock_select_i = '0, timer_d_three_phase_select_i = '0, timer_d_a0_io_bit2_i = '0;
  logic timer_d_a0_io_bit1_i = '0, timer_d_a0_io_bit0_i = '0, pullup_group2_i = '0, pullup_group3_i = '0;
  logic pullup_group4_i = '0, port2_bit0_high_drive_i = '0, pad_p2_0_in_i = '0;
  logic [7:3] port1_data_i = '0, pad_p1_in_i = 5'h0a, pad_p1_out_o, pad_p1_oe_o, pad_p1_pullup_o, port1_read_o;
  logic pad_p2_0_out_o, pad_p2_0_oe_o, pad_p2_0_pullup_o, pad_p2_0_high_drive_o, key_input3_o;
  logic analog_channel11_sel_o, serial0_receive_o, serial0_clock_in_o, timer_a_io_in_o, ext_irq1_o;
  logic timer_d_a0_capture_o, timer_d_ext_clock_o, port2_bit0_read_o, s_tx, s_ck, s_pl, s_w3, s_cm;
  wire serial0_transmit_i, serial0_clock_out_i, timer_a_pulse_i, timer_d_three_phase_wave_i, timer_d_compare_wave_i;
  int err_total = 0;
  int n_checks = 0;

  pfs_periph_model peer (.mclk_i(mclk_i), .nrst_i(nrst_i), .run_i(run), .tx_o(serial0_transmit_i),
    .sclk_o(serial0_clock_out_i), .pulse_o(timer_a_pulse_i), .wave3_o(timer_d_three_phase_wave_i),
    .cmp_o(timer_d_compare_wave_i));
  pfs_pin_select dut (.*);

  // Clock generation
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  // ----------
  // Shared tasks
  // ----------
  task automatic complete_run();
    if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Move pads, note what the peripherals present at the coming edge, pass one cycle
  task automatic cyc();
    pad_p1_in_i = ~pad_p1_in_i;
    pad_p2_0_in_i = ~pad_p2_0_in_i;
    {s_tx, s_ck, s_pl, s_w3, s_cm} = {serial0_transmit_i, serial0_clock_out_i, timer_a_pulse_i,
      timer_d_three_phase_wave_i, timer_d_compare_wave_i};
    @(negedge mclk_i);
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic t_tx();
    logic [2:0] m [4] = '{3'h1, 3'h4, 3'h5, 3'h6};
    logic od;
    pullup_group3_i = 1'h1;
    for (int k = 0; k < 8; k++) begin
      {serial_mode_bit2_i, serial_mode_bit1_i, serial_mode_bit0_i} = m[k % 4];
      serial_open_drain_select_i = k[2];
      cyc();
      od = k[2] && s_tx;
      chk("tx_oe", pad_p1_oe_o[4], !od);
      chk("tx_pullup", pad_p1_pullup_o[4], od);
      if (!od) chk("tx_out", pad_p1_out_o[4], s_tx);
    end
    {serial_mode_bit2_i, serial_mode_bit1_i, serial_mode_bit0_i} = 3'h0;
    port1_bit4_direction_i = 1'h1;
    port1_data_i = 5'h15;
    cyc();
    chk("gp4", {pad_p1_oe_o[4], pad_p1_out_o[4]}, 2'h2);
  endtask
  task automatic t_clk();
    {serial_mode_bit2_i, serial_mode_bit1_i, serial_mode_bit0_i} = 3'h1;
    repeat (2) begin
      cyc();
      chk("clk_out", {pad_p1_oe_o[6], pad_p1_out_o[6]}, {1'h1, s_ck});
    end
    serial_clock_source_select_i = 1'h1;
    repeat (2) begin
      cyc();
      chk("clk_in", {pad_p1_oe_o[6], serial0_clock_in_o}, {1'h0, pad_p1_in_i[6]});
    end
    {serial_mode_bit2_i, serial_mode_bit1_i, serial_mode_bit0_i} = 3'h0;
    port1_bit6_direction_i = 1'h1;
    port1_data_i = 5'h0a;
    cyc();
    chk("gp6", {pad_p1_oe_o[6], pad_p1_out_o[6]}, 2'h3);
  endtask
  task automatic t_ta();
    {timer_a_mode_bit2_i, timer_a_mode_bit1_i, timer_a_mode_bit0_i} = 3'h1;
    for (int s = 0; s < 2; s++) begin
      timer_a_pin_select_i = s[0];
      cyc();
      chk("ta_oe", {pad_p1_oe_o[7], pad_p1_oe_o[5]}, s ? 2'h1 : 2'h2);
      chk("ta_out", s ? pad_p1_out_o[5] : pad_p1_out_o[7], s_pl);
      chk("rx_idle", serial0_receive_o, s ? 1'h1 : pad_p1_in_i[5]);
    end
    {timer_a_mode_bit2_i, timer_a_mode_bit1_i, timer_a_mode_bit0_i} = 3'h2;
    for (int s = 0; s < 2; s++) begin
      timer_a_pin_select_i = s[0];
      ext_irq1_enable_i = s[0];
      cyc();
      chk("ta_in", {timer_a_io_in_o, ext_irq1_o}, s ? {2{pad_p1_in_i[5]}} : {pad_p1_in_i[7], 1'h0});
      chk("rx", serial0_receive_o, pad_p1_in_i[5]);
    end
    {timer_a_mode_bit2_i, timer_a_mode_bit1_i, timer_a_mode_bit0_i} = 3'h1;
    timer_a_output_inhibit_i = 1'h1;
    timer_a_pin_select_i = 1'h0;
    port1_bit7_direction_i = 1'h1;
    port1_data_i = 5'h15;
    cyc();
    chk("inhibit", {pad_p1_oe_o[7], pad_p1_out_o[7]}, 2'h3);
  endtask
  task automatic t_p13();
    {adc_channel_bit2_i, adc_channel_bit1_i, adc_channel_bit0_i} = 3'h7;
    pullup_group2_i = 1'h1;
    for (int k = 0; k < 2; k++) begin
      key_input3_enable_i = !k[0];
      adc_group_select_i = !k[0];
      cyc();
      chk("key3", key_input3_o, k ? 1'h1 : pad_p1_in_i[3]);
      chk("ch11", analog_channel11_sel_o, !k[0]);
      chk("pu3", pad_p1_pullup_o[3], 1'h1);
    end
    port1_bit3_direction_i = 1'h1;
    cyc();
    chk("gp3", {pad_p1_oe_o[3], pad_p1_out_o[3], pad_p1_pullup_o[3]}, 3'h6);
    chk("readback", {port1_read_o, port2_bit0_read_o}, {pad_p1_in_i, pad_p2_0_in_i});
  endtask
  // Timer D control set: output disable, combination, ext clock, three-phase, io bits
  task automatic td(input logic d, input logic [7:0] c);
    port2_bit0_direction_i = d;
    {timer_d_a0_output_disable_i, timer_d_combination_bit1_i, timer_d_combination_bit0_i,
      timer_d_ext_clock_select_i, timer_d_three_phase_select_i, timer_d_a0_io_bit2_i,
      timer_d_a0_io_bit1_i, timer_d_a0_io_bit0_i} = c;
    cyc();
  endtask
  task automatic t_td();
    logic [7:0] w [4] = '{8'h00, 8'h09, 8'h0a, 8'h0b};
    pullup_group4_i = 1'h1;
    port2_bit0_high_drive_i = 1'h1;
    port2_bit0_data_i = 1'h1;
    td(1'h0, 8'h80);
    chk("p20_in", {pad_p2_0_oe_o, pad_p2_0_pullup_o, pad_p2_0_high_drive_o}, 3'h2);
    td(1'h1, 8'h80);
    chk("p20_out", {pad_p2_0_oe_o, pad_p2_0_out_o, pad_p2_0_pullup_o, pad_p2_0_high_drive_o}, 4'hd);
    td(1'h0, 8'h0c);
    chk("capture", timer_d_a0_capture_o, pad_p2_0_in_i);
    td(1'h0, 8'h2c);
    chk("cap_cmd", {timer_d_a0_capture_o, pad_p2_0_oe_o}, 2'h0);
    td(1'h0, 8'h18);
    chk("ext_clock", timer_d_ext_clock_o, pad_p2_0_in_i);
    for (int k = 0; k < 4; k++) begin
      td(1'h0, w[k]);
      chk("wave", {pad_p2_0_oe_o, pad_p2_0_out_o}, {1'h1, k ? s_cm : s_w3});
      chk("wave_hd", pad_p2_0_high_drive_o, 1'h1);
    end
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i);
    nrst_i = 1'h1;
    run = 1'h1;
    t_tx();
    t_clk();
    t_ta();
    t_p13();
    t_td();
    complete_run();
  end
  // Watchdog well beyond the 43 or so cycles the scenarios need
  initial begin
    #20000;
    err_total++;
    complete_run();
  end
endmodule
`default_nettype wire
